//--- rtl/bsi_pkg.sv
// package: register map, flag positions and constants of the status block
package bsi_pkg;
  localparam logic [7:0] ADDR_PAT3 = 8'h10;
  localparam logic [7:0] ADDR_PAT2 = 8'h11;
  localparam logic [7:0] ADDR_PAT1 = 8'h12;
  localparam logic [7:0] ADDR_PAT0 = 8'h13;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_ENABLES = 8'h15;
  localparam int BIT_ALL_ONES = 6;
  localparam int BIT_ALL_ZEROS = 5;
  localparam int BIT_LOCK_LOST = 4;
  localparam int BIT_BIT_ERROR = 3;
  localparam int BIT_BIT_COUNT_OVF = 2;
  localparam int BIT_ERR_COUNT_OVF = 1;
  localparam int BIT_LOCKED = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] ENABLES_USED = 8'h7f;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  localparam logic [5:0] RUN_LIMIT = 6'h20;
endpackage

//--- rtl/bsi_run_detect.sv
// run detector: flags 32 equal received bits in a row
`timescale 1ns/1ps
`default_nettype none
module bsi_run_detect (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bit_valid,
  input wire logic bit_value,
  output logic run_ones,
  output logic run_zeros
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic last_r;
  logic last_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    last_nxt = last_r;
    if (bit_valid) begin
      last_nxt = bit_value;
      if (bit_value != last_r || cnt_r == 6'h00) begin
        cnt_nxt = 6'h01;
      end else if (cnt_r != bsi_pkg::RUN_LIMIT) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 6'h00;
      last_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      last_r <= last_nxt;
    end
  end

  // condition lasts until the opposite bit arrives
  assign run_ones = (cnt_r == bsi_pkg::RUN_LIMIT) && last_r;
  assign run_zeros = (cnt_r == bsi_pkg::RUN_LIMIT) && !last_r;
endmodule
`default_nettype wire

//--- rtl/bsi_status_irq.sv
// receive status flags, interrupt enables and captured pattern registers
// ----------------------------------------------------------------------
// Overview of operation
// (RULE1) events set their matching status bit
// (RULE2) lock-state bit follows synchronizer live
// (RULE3) other bits latch until software reads
// (RULE4) error and overflow flags clear on read
// (RULE5) alarm flags clear on read once condition ends
// (RULE6) status events can drive interrupt pin
// (RULE7) each flag has same-position mask bit
// (RULE8) mask 0 blocks, mask 1 enables interrupt
// (RULE9) all-zeros after 32 zeros, clearable on one
// (RULE10) lock-lost set while searching, held until read
// (RULE11) status register at 14h, bit layout
// (RULE12) mask register at 15h, same layout
// (RULE13) all-ones after 32 ones, clearable on zero
// (RULE14) interrupt low while any enabled flag set
// (RULE15) bit-count overflow sets its flag
// (RULE16) error-count overflow sets its flag
// (RULE17) latch out of lock copies last 32 bits
// (RULE18) latch in lock copies locked pattern
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bsi_status_irq (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic locked,
  input wire logic searching,
  input wire logic bit_error_evt,
  input wire logic bit_count_ovf_evt,
  input wire logic err_count_ovf_evt,
  input wire logic [31:0] locked_pattern,
  input wire logic receive_latch_control,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq_n
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0] flags_r;
  wire logic [7:0] flags_nxt;
  logic [7:0] enables_r;
  logic [7:0] enables_nxt;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [31:0] pattern_r;
  logic [31:0] pattern_nxt;
  logic latch_prev_r;
  logic latch_prev_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_n_r;
  logic irq_n_nxt;
  logic run_ones;
  logic run_zeros;
  logic [7:0] set_vec;
  logic [7:0] hold_vec;
  logic [7:0] live_flags;
  logic flag_read;
  logic [7:0] pend_vec;
  logic latch_rise;

  bsi_run_detect u_run (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .bit_valid(bit_valid),
    .bit_value(bit_value),
    .run_ones(run_ones),
    .run_zeros(run_zeros)
  );

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  always_comb begin
    set_vec = 8'h00;
    set_vec[bsi_pkg::BIT_ALL_ONES] = run_ones; // [RULE13] [RULE1]
    set_vec[bsi_pkg::BIT_ALL_ZEROS] = run_zeros; // [RULE9]
    set_vec[bsi_pkg::BIT_LOCK_LOST] = searching; // [RULE10]
    set_vec[bsi_pkg::BIT_BIT_ERROR] = bit_error_evt;
    set_vec[bsi_pkg::BIT_BIT_COUNT_OVF] = bit_count_ovf_evt; // [RULE15]
    set_vec[bsi_pkg::BIT_ERR_COUNT_OVF] = err_count_ovf_evt; // [RULE16]
  end

  // causes still present at a read; only the alarm flags have one
  always_comb begin
    hold_vec = 8'h00;
    hold_vec[bsi_pkg::BIT_ALL_ONES] = run_ones; // [RULE5]
    hold_vec[bsi_pkg::BIT_ALL_ZEROS] = run_zeros; // [RULE5]
    hold_vec[bsi_pkg::BIT_LOCK_LOST] = searching; // [RULE5]
  end

  assign flag_read = reg_rd && (reg_addr == bsi_pkg::ADDR_FLAGS); // [RULE11]

  // one slice per flag; bit 7 and the live lock bit never latch
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (i == 7 || i == bsi_pkg::BIT_LOCKED) begin : g_fixed
      assign flags_nxt[i] = 1'b0; // [RULE2] [RULE11]
    end else begin : g_latched
      // a set in the read cycle wins over the clear
      assign flags_nxt[i] = flag_read ? (set_vec[i] | hold_vec[i])
        : (flags_r[i] | set_vec[i]); // [RULE3] [RULE4]
    end
  end

  // ----------------------------------------------------------------------
  // mask register and interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    enables_nxt = enables_r;
    if (reg_wr && reg_addr == bsi_pkg::ADDR_ENABLES) begin
      enables_nxt = reg_wdata & bsi_pkg::ENABLES_USED; // [RULE12]
    end
  end

  always_comb begin
    live_flags = flags_r;
    live_flags[bsi_pkg::BIT_LOCKED] = locked; // [RULE2]
    // enabled flags as they will stand after this edge, plus the live lock
    pend_vec = (flags_nxt | {7'h00, locked}) & enables_nxt; // [RULE7] [RULE8]
    // pin registered from the next flag state, so it changes on the same edge as the flags
    irq_n_nxt = ~|pend_vec; // [RULE6] [RULE14]
  end

  // ----------------------------------------------------------------------
  // captured pattern
  // ----------------------------------------------------------------------
  assign latch_rise = receive_latch_control && !latch_prev_r;

  always_comb begin
    shift_nxt = shift_r;
    if (bit_valid) begin
      shift_nxt = {shift_r[30:0], bit_value};
    end
    latch_prev_nxt = receive_latch_control;
    pattern_nxt = pattern_r;
    // only the rising edge captures, so a held control copies once
    if (latch_rise) begin
      if (locked) begin
        pattern_nxt = locked_pattern; // [RULE18]
      end else begin
        pattern_nxt = shift_r; // [RULE17]
      end
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        bsi_pkg::ADDR_PAT3: rdata_nxt = pattern_r[31:24];
        bsi_pkg::ADDR_PAT2: rdata_nxt = pattern_r[23:16];
        bsi_pkg::ADDR_PAT1: rdata_nxt = pattern_r[15:8];
        bsi_pkg::ADDR_PAT0: rdata_nxt = pattern_r[7:0];
        bsi_pkg::ADDR_FLAGS: rdata_nxt = live_flags; // [RULE11]
        bsi_pkg::ADDR_ENABLES: rdata_nxt = enables_r;
        default: rdata_nxt = 8'h00;
      endcase
    end else begin
      rdata_nxt = rdata_r;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= bsi_pkg::FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enables_r <= bsi_pkg::ENABLES_RESET;
    end else begin
      enables_r <= enables_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= bsi_pkg::PATTERN_RESET;
      pattern_r <= bsi_pkg::PATTERN_RESET;
      latch_prev_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      pattern_r <= pattern_nxt;
      latch_prev_r <= latch_prev_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= irq_n_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq_n = irq_n_r;
endmodule
`default_nettype wire

//--- tb/bsi_asserts.sv
// checker: port assertions of the status block
`timescale 1ns/1ps
`default_nettype none
module bsi_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic locked,
  input wire logic bit_error_evt,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic rf = reg_rd && reg_addr == 8'h14;
  wire logic mw = reg_wr && reg_addr == 8'h15;
  // last mask written, bit 7 reads back as zero
  logic [7:0] mask_seen_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_seen_r <= 8'h00;
    end else if (mw) begin
      mask_seen_r <= reg_wdata & 8'h7f;
    end
  end
  a_lock_live: assert property (rf |=> reg_rdata[0] == $past(locked))
    else $error("lock bit");
  a_top_unused: assert property (rf |=> !reg_rdata[7])
    else $error("bit 7 set");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h15 |=>
    reg_rdata == 8'h00) else $error("unmapped data");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_mask_back: assert property (reg_rd && reg_addr == 8'h15 |=>
    reg_rdata == $past(mask_seen_r)) else $error("mask");
  a_err_sets: assert property (bit_error_evt ##1 (!rf) [*2] ##1 rf |=>
    reg_rdata[3]) else $error("error flag");
  a_mask_off: assert property (mw && reg_wdata == 8'h00 ##1 !reg_wr
    |=> irq_n) else $error("masked irq");
  a_irq_lock: assert property (mw && reg_wdata == 8'h01 ##1
    locked && !reg_wr ##1 locked |-> !irq_n) else $error("lock irq");
endmodule
`default_nettype wire

//--- tb/bsi_host.sv
// host model: register cycles on the control port
`timescale 1ns/1ps
`default_nettype none
module bsi_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_rd = 1'h0,
  output logic reg_wr = 1'h0,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
    // released data no longer shows the last value
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = ad;
    reg_rd = 1'h1;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// testbench: flags, masks, interrupt and pattern capture
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, arst_n = 0, bit_valid = 0, bit_value = 0, locked = 0;
  logic searching = 0, be = 0, bc = 0, ec = 0, rlc = 0;
  logic [31:0] pat = 32'h0, sent = 32'h0;
  logic [7:0] a, wd, rdata, got, r8;
  logic rr, rw, irq_n;
  integer err_total = 0, num_checks = 0, cyc = 0, seed = 32'h1735;
  bsi_host host_i (.ref_clk, .reg_rdata(rdata), .reg_addr(a), .reg_rd(rr),
    .reg_wr(rw), .reg_wdata(wd));
  bsi_status_irq bsi_status_irq_i (.ref_clk, .arst_n, .bit_valid,
    .bit_value, .locked, .searching, .bit_error_evt(be),
    .bit_count_ovf_evt(bc), .err_count_ovf_evt(ec), .locked_pattern(pat),
    .receive_latch_control(rlc), .reg_addr(a), .reg_rd(rr), .reg_wr(rw),
    .reg_wdata(wd), .reg_rdata(rdata), .irq_n);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    host_i.rd(ad, got);
    chk(got, e);
  endtask
  task automatic bits(input int n, input logic v, input logic r);
    for (int k = 0; k < n; k++) begin
      @(negedge ref_clk);
      bit_valid = 1'h1;
      bit_value = r ? 1'($random(seed)) : v;
      sent = {sent[30:0], bit_value};
      @(negedge ref_clk);
      bit_valid = 1'h0;
    end
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    arst_n = 1'h1;
    rdc(8'h14, 8'h00);
    rdc(8'h20, 8'h00);
    r8 = 8'($random(seed));
    host_i.wr(8'h15, r8);
    rdc(8'h15, r8 & 8'h7f);
    host_i.wr(8'h15, 8'h08);
    @(negedge ref_clk);
    {be, bc, ec} = 3'h7;
    @(negedge ref_clk);
    {be, bc, ec} = 3'h0;
    @(negedge ref_clk);
    chk({7'h0, irq_n}, 8'h00);
    rdc(8'h14, 8'h0e);
    chk({7'h0, irq_n}, 8'h01);
    rdc(8'h14, 8'h00);
    bits(32, 1'h0, 1'h0);
    rdc(8'h14, 8'h20);
    chk({7'h0, irq_n}, 8'h01);
    rdc(8'h14, 8'h20);
    bits(31, 1'h1, 1'h0);
    rdc(8'h14, 8'h20);
    rdc(8'h14, 8'h00);
    bits(1, 1'h1, 1'h0);
    rdc(8'h14, 8'h40);
    searching = 1'h1;
    rdc(8'h14, 8'h50);
    {locked, searching} = 2'h2;
    rdc(8'h14, 8'h51);
    rdc(8'h14, 8'h41);
    host_i.wr(8'h15, 8'h01);
    @(negedge ref_clk);
    chk({7'h0, irq_n}, 8'h00);
    host_i.wr(8'h15, 8'h00);
    @(negedge ref_clk);
    chk({7'h0, irq_n}, 8'h01);
    locked = 1'h0;
    bits(32, 1'h0, 1'h1);
    rlc = 1'h1;
    for (int k = 0; k < 4; k++)
      rdc(8'(8'h10 + k), sent[31 - 8 * k -: 8]);
    {locked, rlc} = 2'h2;
    pat = 32'($random(seed));
    @(negedge ref_clk);
    rlc = 1'h1;
    for (int k = 0; k < 4; k++)
      rdc(8'(8'h10 + k), pat[31 - 8 * k -: 8]);
    give_verdict();
  end
endmodule
bind bsi_status_irq bsi_chk bsi_chk_i (.ref_clk, .arst_n, .locked,
  .bit_error_evt, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
  .irq_n);
`default_nettype wire
